// [rtl/dzo_cfg.svh]
/*
 * Constants of the detector zone output block: sizes, register offsets,
 * field positions and timing counts.
 * Assumes inclusion by bare name from the design file and the testbench.
 */
`ifndef DZO_CFG_SVH
`define DZO_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define DZO_NZ 24
`define DZO_NCH 8
`define DZO_NCNT 6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DZO_CLK_NS 50
`define DZO_TENTH_NS 100000000
`define DZO_FPS 30
`define DZO_T_MIN 8'h01
`define DZO_T_MAX 8'hfa
`define DZO_IV5 16'h0bb8
`define DZO_IV15 16'h2328
`define DZO_IV30 16'h4650
`define DZO_IV60 16'h8ca0
`define DZO_ISEL_CYCLE 3'h4
`define DZO_FAIL_PER 7'h64
`define DZO_MIN_ON 7'h0a
`define DZO_FIX_ON 7'h32

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DZO_CTRL 8'h00
`define DZO_BIKE 8'h04
`define DZO_ANDM 8'h08
`define DZO_CHEN 8'h0c
`define DZO_FAIL 8'h10
`define DZO_STAT 8'h14
`define DZO_ZPRES 8'h18
`define DZO_ZCFG 8'h40
`define DZO_ZEND 8'ha0
`define DZO_VCNT 8'ha0
`define DZO_VEND 8'hb8
`define DZO_BCNT 8'hc0
`define DZO_BEND 8'hd8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DZO_EDIT_BIT 8
`define DZO_EDIT_ZLSB 16

`endif

// [rtl/dzo_pkg.sv]
/*
 * Types of the detector zone output block.
 * Assumes nothing beyond the constants header.
 */
package dzo_pkg;

    // Output timing mode of a zone
    typedef enum logic [1:0] {
        MODE_PRES = 2'h0,
        MODE_PULSE = 2'h1,
        MODE_EXT = 2'h2,
        MODE_DLY = 2'h3
    } mode_t;

    // Safe output on video loss
    typedef enum logic [1:0] {
        FAIL_MIN = 2'h0,
        FAIL_FIXED = 2'h1,
        FAIL_CONST = 2'h2,
        FAIL_CONST_ALT = 2'h3
    } fail_t;

    // Zone configuration word, as laid out in the register
    typedef struct packed {
        logic [7:0] tenths;
        logic [1:0] pad;
        mode_t mode;
        logic [2:0] chan;
        logic en;
    } zcfg_t;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// [rtl/zone_output.sv]
/*
 * Detector zone output logic: turns per-zone presence from the image
 * engine into detector channel calls, with timing modes, fail-safe
 * calls and interval count collection, behind an APB register file.
 * Assumes presence inputs and frame strobe synchronous to clk_i.
 */
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "dzo_cfg.svh"

module zone_output #(
    parameter int unsigned TENTH_CYCLES = `DZO_TENTH_NS / `DZO_CLK_NS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire dzo_pkg::apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [`DZO_NZ-1:0] zone_veh_i,
    input wire logic [`DZO_NZ-1:0] zone_bike_i,
    input wire logic [`DZO_NZ-1:0] zone_dir_ok_i,
    input wire logic frame_tick_i,
    input wire logic video_ok_i,
    input wire logic learning_i,
    input wire logic low_vis_i,
    input wire logic cycle_end_i,
    input wire logic [`DZO_NCNT-1:0] bike_cnt_i,
    output logic [`DZO_NCH-1:0] chan_o,
    output logic [`DZO_NZ-1:0] flash_o
);

    // ------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------
    logic [2:0] isel_q;
    logic edit_q;
    logic [4:0] edit_zone_q;
    logic [`DZO_NZ-1:0] bike_q;
    logic [`DZO_NCH-1:0] and_q;
    logic [`DZO_NCH-1:0] chen_q;
    logic [2*`DZO_NCH-1:0] fail_q;
    dzo_pkg::zcfg_t zcfg_q [`DZO_NZ];

    logic [`DZO_NZ-1:0] pres;
    logic [`DZO_NZ-1:0] rise;
    logic [`DZO_NZ-1:0] zout;
    logic [`DZO_NCH-1:0] chan_d;
    logic [15:0] vcnt_rep [`DZO_NCNT];
    logic [15:0] vocc_rep [`DZO_NCNT];
    logic [15:0] bcnt_rep [`DZO_NCNT];

    // ------------------------------------------------------------
    // Tenth-second tick
    // ------------------------------------------------------------
    logic [31:0] pre_q;
    logic tick_q;

    // Time base for every programmed time
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pre_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (pre_q == TENTH_CYCLES - 32'd1) begin
            pre_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 32'd1;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic acc;
    logic wr;
    logic [7:0] addr;
    logic hit_hi;
    logic [7:0] zoff;
    logic [7:0] voff;
    logic [7:0] boff;
    logic [31:0] rdata_d;
    logic err_d;

    assign acc = apb_i.psel & apb_i.penable;
    assign wr = acc & pready_o & apb_i.pwrite;
    assign addr = apb_i.paddr[7:0];
    assign hit_hi = (apb_i.paddr[11:8] == 4'h0) & (apb_i.paddr[1:0] == 2'h0);
    assign zoff = addr - `DZO_ZCFG;
    assign voff = addr - `DZO_VCNT;
    assign boff = addr - `DZO_BCNT;

    // Clamp a programmed time into its legal range
    function automatic logic [7:0] clamp_t(input logic [7:0] v);
        if (v < `DZO_T_MIN) begin
            return `DZO_T_MIN;
        end else if (v > `DZO_T_MAX) begin
            return `DZO_T_MAX;
        end
        return v;
    endfunction

    // Read data and error decode
    always_comb begin
        rdata_d = 32'h0;
        err_d = 1'b0;
        if (!hit_hi) begin
            err_d = 1'b1;
        end else if (addr >= `DZO_ZCFG && addr < `DZO_ZEND) begin
            rdata_d[15:0] = zcfg_q[zoff[6:2]];
        end else if (addr >= `DZO_VCNT && addr < `DZO_VEND) begin
            rdata_d = {vocc_rep[voff[4:2]], vcnt_rep[voff[4:2]]};
        end else if (addr >= `DZO_BCNT && addr < `DZO_BEND) begin
            rdata_d[15:0] = bcnt_rep[boff[4:2]];
        end else begin
            case (addr)
                `DZO_CTRL: begin
                    rdata_d[2:0] = isel_q;
                    rdata_d[`DZO_EDIT_BIT] = edit_q;
                    rdata_d[`DZO_EDIT_ZLSB +: 5] = edit_zone_q;
                end
                `DZO_BIKE: rdata_d[`DZO_NZ-1:0] = bike_q;
                `DZO_ANDM: rdata_d[`DZO_NCH-1:0] = and_q;
                `DZO_CHEN: rdata_d[`DZO_NCH-1:0] = chen_q;
                `DZO_FAIL: rdata_d[2*`DZO_NCH-1:0] = fail_q;
                `DZO_STAT: rdata_d[10:0] = {low_vis_i, learning_i, video_ok_i, chan_o};
                `DZO_ZPRES: rdata_d[`DZO_NZ-1:0] = zout;
                default: err_d = 1'b1;
            endcase
        end
    end

    // One wait state, then answer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= acc & !pready_o;
            if (acc & !pready_o) begin
                prdata_o <= apb_i.pwrite ? 32'h0 : rdata_d;
                pslverr_o <= err_d;
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

    // Register writes, kept for the storage engine to save and restore
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            isel_q <= 3'h0;
            edit_q <= 1'b0;
            edit_zone_q <= 5'h0;
            bike_q <= '0;
            and_q <= '0;
            chen_q <= '0;
            fail_q <= '0;
            for (int i = 0; i < `DZO_NZ; i++) begin
                zcfg_q[i] <= dzo_pkg::zcfg_t'({`DZO_T_MIN, 8'h00});
            end
        end else if (wr && hit_hi) begin
            if (addr >= `DZO_ZCFG && addr < `DZO_ZEND) begin
                zcfg_q[zoff[6:2]] <= dzo_pkg::zcfg_t'(
                    {clamp_t(apb_i.pwdata[15:8]), 2'h0, apb_i.pwdata[5:0]});
            end else begin
                case (addr)
                    `DZO_CTRL: begin
                        isel_q <= apb_i.pwdata[2:0];
                        edit_q <= apb_i.pwdata[`DZO_EDIT_BIT];
                        edit_zone_q <= apb_i.pwdata[`DZO_EDIT_ZLSB +: 5];
                    end
                    `DZO_BIKE: bike_q <= apb_i.pwdata[`DZO_NZ-1:0];
                    `DZO_ANDM: and_q <= apb_i.pwdata[`DZO_NCH-1:0];
                    `DZO_CHEN: chen_q <= apb_i.pwdata[`DZO_NCH-1:0];
                    `DZO_FAIL: fail_q <= apb_i.pwdata[2*`DZO_NCH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Per-zone presence and timing
    // ------------------------------------------------------------
    for (genvar z = 0; z < `DZO_NZ; z++) begin : g_zone
        logic pres_q;
        logic prev_q;
        logic [7:0] tmr_q;
        logic raw;
        logic zo;
        dzo_pkg::zcfg_t cfg;

        assign cfg = zcfg_q[z];
        // Direction gate, bicycle/vehicle split, low-visibility force
        assign raw = cfg.en & (low_vis_i | (zone_dir_ok_i[z] &
            (bike_q[z] ? zone_bike_i[z] : zone_veh_i[z])));

        // Sampled once per video frame
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                pres_q <= 1'b0;
                prev_q <= 1'b0;
            end else begin
                if (frame_tick_i) begin
                    pres_q <= raw;
                end
                prev_q <= pres_q;
            end
        end

        // Mode timer, in tenths of a second
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                tmr_q <= 8'h0;
            end else begin
                case (cfg.mode)
                    dzo_pkg::MODE_PULSE: begin
                        if (pres_q & !prev_q) begin
                            tmr_q <= cfg.tenths;
                        end else if (tick_q && tmr_q != 8'h0) begin
                            tmr_q <= tmr_q - 8'h1;
                        end
                    end
                    dzo_pkg::MODE_EXT: begin
                        if (pres_q) begin
                            tmr_q <= cfg.tenths;
                        end else if (tick_q && tmr_q != 8'h0) begin
                            tmr_q <= tmr_q - 8'h1;
                        end
                    end
                    dzo_pkg::MODE_DLY: begin
                        if (!pres_q) begin
                            tmr_q <= 8'h0;
                        end else if (tick_q && tmr_q < cfg.tenths) begin
                            tmr_q <= tmr_q + 8'h1;
                        end
                    end
                    default: tmr_q <= 8'h0;
                endcase
            end
        end

        // Zone output by mode, one local value per zone
        always_comb begin
            case (cfg.mode)
                dzo_pkg::MODE_PULSE: zo = tmr_q != 8'h0;
                dzo_pkg::MODE_EXT: zo = pres_q | (tmr_q != 8'h0);
                dzo_pkg::MODE_DLY: zo = pres_q & (tmr_q >= cfg.tenths);
                default: zo = pres_q;
            endcase
        end

        assign zout[z] = zo;
        assign pres[z] = pres_q;
        assign rise[z] = pres_q & !prev_q;
    end

    // ------------------------------------------------------------
    // Fail-safe recall pattern
    // ------------------------------------------------------------
    logic [6:0] fcnt_q;

    // Ten-second recall period
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fcnt_q <= 7'h0;
        end else if (tick_q) begin
            fcnt_q <= (fcnt_q == `DZO_FAIL_PER - 7'h1) ? 7'h0 : fcnt_q + 7'h1;
        end
    end

    // ------------------------------------------------------------
    // Channel combining and output priority
    // ------------------------------------------------------------
    logic edit_ok;
    logic [2:0] edit_ch;

    assign edit_ok = edit_q & (edit_zone_q < 5'(`DZO_NZ));
    assign edit_ch = edit_ok ? zcfg_q[edit_zone_q].chan : 3'h0;

    for (genvar c = 0; c < `DZO_NCH; c++) begin : g_chan
        logic [`DZO_NZ-1:0] map;
        logic any_z;
        logic all_z;
        logic hold;
        logic [1:0] fm;
        logic fail_call;

        // Zones routed to this channel
        always_comb begin
            for (int z = 0; z < `DZO_NZ; z++) begin
                map[z] = zcfg_q[z].en & (zcfg_q[z].chan == 3'(c));
            end
        end

        assign any_z = |(zout & map);
        assign all_z = (|map) & (&(zout | ~map));
        assign hold = edit_ok & (edit_ch == 3'(c));
        assign fm = fail_q[2*c +: 2];
        assign fail_call = (fm == dzo_pkg::FAIL_MIN) ? (fcnt_q < `DZO_MIN_ON) :
            (fm == dzo_pkg::FAIL_FIXED) ? (fcnt_q < `DZO_FIX_ON) : 1'b1;

        // Priority: disabled, learning, edit hold, video loss, normal
        assign chan_d[c] = !chen_q[c] ? 1'b0 :
            (learning_i | hold) ? 1'b1 :
            !video_ok_i ? fail_call :
            and_q[c] ? all_z : any_z;
    end

    // Registered channel and overlay outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            chan_o <= '0;
            flash_o <= '0;
        end else begin
            chan_o <= chan_d;
            flash_o <= zout;
        end
    end

    // ------------------------------------------------------------
    // Interval data collection
    // ------------------------------------------------------------
    logic [15:0] ivc_q;
    logic [15:0] iv_lim;
    logic iv_end;

    always_comb begin
        case (isel_q)
            3'h0: iv_lim = `DZO_IV5;
            3'h1: iv_lim = `DZO_IV15;
            3'h2: iv_lim = `DZO_IV30;
            default: iv_lim = `DZO_IV60;
        endcase
    end

    assign iv_end = (isel_q == `DZO_ISEL_CYCLE) ? cycle_end_i :
        (tick_q && ivc_q >= iv_lim - 16'h1);

    // Interval timer in tenths
    always_ff @(posedge clk_i) begin
        if (srst_i || iv_end) begin
            ivc_q <= 16'h0;
        end else if (tick_q) begin
            ivc_q <= ivc_q + 16'h1;
        end
    end

    for (genvar k = 0; k < `DZO_NCNT; k++) begin : g_cnt
        logic [15:0] vc_q;
        logic [15:0] vo_q;
        logic [15:0] bc_q;
        logic [15:0] vcr_q;
        logic [15:0] vor_q;
        logic [15:0] bcr_q;
        logic occ;

        assign occ = frame_tick_i & pres[k];

        // Accumulate; an event at interval end opens the next interval
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                vc_q <= 16'h0;
                vo_q <= 16'h0;
                bc_q <= 16'h0;
                vcr_q <= 16'h0;
                vor_q <= 16'h0;
                bcr_q <= 16'h0;
            end else if (iv_end) begin
                vcr_q <= vc_q;
                vor_q <= vo_q;
                bcr_q <= bc_q;
                vc_q <= {15'h0, rise[k]};
                vo_q <= {15'h0, occ};
                bc_q <= {15'h0, bike_cnt_i[k]};
            end else begin
                vc_q <= vc_q + {15'h0, rise[k]};
                vo_q <= vo_q + {15'h0, occ};
                bc_q <= bc_q + {15'h0, bike_cnt_i[k]};
            end
        end

        assign vcnt_rep[k] = vcr_q;
        assign vocc_rep[k] = vor_q;
        assign bcnt_rep[k] = bcr_q;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_learn_call: assert property (
        learning_i && chen_q[0] |=> chan_o[0])
        else $error("learning did not hold a call");
    chk_edit_hold: assert property (
        edit_ok && chen_q[edit_ch] |=> chan_o[$past(edit_ch)])
        else $error("edited zone channel not held");
    chk_bike_only: assert property (
        frame_tick_i && !low_vis_i && bike_q[1] && !zone_bike_i[1] |=> !pres[1])
        else $error("bicycle zone followed non-bicycle");
    chk_dir_gate: assert property (
        frame_tick_i && !low_vis_i && !zone_dir_ok_i[0] |=> !pres[0])
        else $error("wrong direction detected");
    chk_low_vis: assert property (
        frame_tick_i && low_vis_i && zcfg_q[0].en |=> pres[0])
        else $error("low visibility did not force zone");
    chk_time_range: assert property (
        zcfg_q[0].tenths >= `DZO_T_MIN && zcfg_q[0].tenths <= `DZO_T_MAX)
        else $error("zone time out of range");
    chk_pulse_start: assert property (
        zcfg_q[0].mode == dzo_pkg::MODE_PULSE && rise[0] && $stable(zcfg_q[0])
        |=> zout[0] [*2])
        else $error("pulse did not start");
    chk_delay_hold: assert property (
        zcfg_q[0].mode == dzo_pkg::MODE_DLY && !pres[0] |-> !zout[0])
        else $error("delay output without presence");
    chk_fail_const: assert property (
        !video_ok_i && chen_q[0] && fail_q[1:0] == dzo_pkg::FAIL_CONST |=> chan_o[0])
        else $error("constant recall missing");
    chk_or_combine: assert property (
        chen_q[0] && !and_q[0] && video_ok_i && !learning_i && !g_chan[0].hold
        && g_chan[0].any_z |=> chan_o[0])
        else $error("OR combine dropped a call");

    cov_video_loss: cover property (video_ok_i ##1 !video_ok_i);
    cov_edit: cover property (edit_ok ##1 !edit_ok);
    cov_iv_end: cover property (iv_end && vcnt_rep[0] != 16'h0);
    cov_extend: cover property (zcfg_q[0].mode == dzo_pkg::MODE_EXT && !pres[0] && zout[0]);

endmodule // zone_output

// [bench/ctrl_model.sv]
/*
 * Controller detector input model: watches call line 0.
 * Assumes calls synchronous to the block clock.
 */
`timescale 1ns/100ps
module ctrl_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] call_i,
    output logic [15:0] onset_o
);
    logic prev_q;
    // Counts call onsets on channel 0
    always_ff @(posedge clk_i) begin
        prev_q <= srst_i ? 1'b0 : call_i[0];
        if (srst_i) begin
            onset_o <= 16'h0;
        end else if (call_i[0] && !prev_q) begin
            onset_o <= onset_o + 16'h1;
        end
    end
endmodule // ctrl_model

// [bench/detector_zone_output_logic_tb_top.sv]
/*
 * Testbench of the zone output block: APB master, zone stimulus, checks.
 * Assumes the package and constants header on the include path.
 */
`timescale 1ns/100ps
`include "dzo_cfg.svh"
module detector_zone_output_logic_tb_top;
    logic clk = 0, srst = 1, tick = 0, vok = 1, lrn = 0, lv = 0, cyc = 0, er, pready, pslverr;
    dzo_pkg::apb_req_t apb = '0;
    logic [31:0] prdata, rd, seed = 32'h7c7f;
    logic [23:0] veh = 0, bike = 0, dir = '1, flash;
    logic [7:0] chan;
    logic [5:0] bc = 0;
    logic [15:0] onsets;
    logic [1:0] tk = 0;
    logic [2:0] ea [4] = '{3'b111, 3'b110, 3'b110, 3'b001};
    int err_count = 0, num_checks = 0, cycles = 0;

    zone_output #(.TENTH_CYCLES(10)) i_zone_output (.clk_i(clk), .srst_i(srst), .apb_i(apb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .zone_veh_i(veh),
        .zone_bike_i(bike), .zone_dir_ok_i(dir), .frame_tick_i(tick), .video_ok_i(vok),
        .learning_i(lrn), .low_vis_i(lv), .cycle_end_i(cyc), .bike_cnt_i(bc),
        .chan_o(chan), .flash_o(flash));
    ctrl_model i_ctrl_model (.clk_i(clk), .srst_i(srst), .call_i(chan), .onset_o(onsets));

    initial begin
        forever #25 clk = ~clk;
    end

    // Frame strobe every fourth cycle, run ceiling
    always @(posedge clk) begin
        tk <= tk + 2'h1;
        tick <= (tk == 2'h2);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [31:0] zc(input logic [2:0] ch, input logic [1:0] m,
                                       input logic [7:0] t);
        dzo_pkg::zcfg_t c;
        c = '{tenths: t, pad: 2'h0, mode: dzo_pkg::mode_t'(m), chan: ch, en: 1'b1};
        return {16'h0, c};
    endfunction

    // Idle cycles with random traffic on zones 4 to 23
    task automatic w(input int n);
        repeat (n) begin
            @(posedge clk);
            seed = xs(seed);
            veh[23:4] <= seed[19:0];
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask

    // One APB transfer, held until pready
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask

    task automatic conclude();
        $display("mismatches %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        int f;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        w(2);
        chk(chan, 0);
        chk(flash, 0);
        seed = xs(seed);
        n = seed[7:0];
        bus(1'b1, `DZO_CHEN, seed);
        bus(1'b0, `DZO_CHEN, 0);
        chk(rd, n);
        bus(1'b1, `DZO_CHEN, 32'hff);
        bus(1'b0, 12'h0fc, 0);
        chk(er, 1);
        chk(rd, 0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `DZO_CTRL, i);
            bus(1'b0, `DZO_CTRL, 0);
            chk(rd[2:0], i[2:0]);
        end
        bus(1'b1, `DZO_ZCFG, zc(0, 0, 0));
        bus(1'b0, `DZO_ZCFG, 0);
        chk(rd[15:8], 1);
        bus(1'b1, `DZO_ZCFG, zc(0, 0, 8'hff));
        bus(1'b0, `DZO_ZCFG, 0);
        chk(rd[15:8], 8'hfa);
        bus(1'b1, 12'(`DZO_ZCFG + 92), zc(7, 0, 8'h01));
        bus(1'b0, 12'(`DZO_ZCFG + 92), 0);
        chk(rd[3:0], 4'hf);
        veh[0] <= 1'b1;
        w(8);
        chk(chan[0], 1);
        chk(flash[0], 1);
        dir[0] <= 1'b0;
        w(8);
        chk(chan[0], 0);
        dir[0] <= 1'b1;
        veh[0] <= 1'b0;
        w(8);
        // Presence, pulse, extend, delay at half a second
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `DZO_ZCFG, zc(0, m[1:0], 8'h05));
            veh[0] <= 1'b1;
            w(12);
            chk(chan[0], ea[m][2]);
            if (m == 2) veh[0] <= 1'b0;
            w(12);
            chk(chan[0], ea[m][1]);
            w(60);
            chk(chan[0], ea[m][0]);
            veh[0] <= 1'b0;
            w(80);
        end
        chk(onsets, 5);
        bus(1'b1, `DZO_ZCFG, zc(0, 0, 8'h01));
        bus(1'b1, `DZO_BIKE, 32'h2);
        bus(1'b1, 12'(`DZO_ZCFG + 4), zc(1, 0, 8'h01));
        veh[1] <= 1'b1;
        w(8);
        chk(chan[1], 0);
        bike[1] <= 1'b1;
        w(8);
        chk(chan[1], 1);
        bus(1'b1, `DZO_CTRL, 32'h104);
        w(8);
        chk(chan[0], 1);
        bike[1] <= 1'b0;
        w(8);
        chk(chan[1], 0);
        bus(1'b1, `DZO_CTRL, 32'h4);
        w(8);
        chk(chan[0], 0);
        // Extension time on a bicycle zone of its own
        bus(1'b1, 12'(`DZO_ZCFG + 4), zc(1, 2, 8'h02));
        bike[1] <= 1'b1;
        w(8);
        bike[1] <= 1'b0;
        w(8);
        chk(chan[1], 1);
        w(30);
        chk(chan[1], 0);
        bus(1'b1, `DZO_ANDM, 32'h4);
        bus(1'b1, 12'(`DZO_ZCFG + 8), zc(2, 0, 8'h01));
        bus(1'b1, 12'(`DZO_ZCFG + 12), zc(2, 0, 8'h01));
        veh[2] <= 1'b1;
        w(8);
        chk(chan[2], 0);
        veh[3] <= 1'b1;
        w(8);
        chk(chan[2], 1);
        bus(1'b1, `DZO_ANDM, 32'h0);
        veh[3] <= 1'b0;
        w(8);
        chk(chan[2], 1);
        veh[3:0] <= 4'h0;
        lrn <= 1'b1;
        w(8);
        chk(chan, 8'hff);
        lrn <= 1'b0;
        lv <= 1'b1;
        w(8);
        chk(chan[0], 1);
        lv <= 1'b0;
        w(8);
        chk(chan[0], 0);
        bus(1'b1, `DZO_FAIL, 32'h2);
        vok <= 1'b0;
        w(8);
        chk(chan[0], 1);
        // Minimum and fixed recall duty over one whole recall period
        bus(1'b1, `DZO_FAIL, 32'h4);
        w(2);
        n = 0;
        f = 0;
        repeat (`DZO_FAIL_PER * 10) begin
            w(1);
            n += chan[0];
            f += chan[1];
        end
        chk(n, `DZO_MIN_ON * 10);
        chk(f, `DZO_FIX_ON * 10);
        vok <= 1'b1;
        w(8);
        // One interval of counts, closed by cycle ends
        cyc <= 1'b1;
        w(1);
        cyc <= 1'b0;
        n = seed[2:0] + 1;
        repeat (n) begin
            bc[0] <= 1'b1;
            w(1);
            bc[0] <= 1'b0;
            w(1);
        end
        repeat (2) begin
            veh[0] <= 1'b1;
            w(8);
            veh[0] <= 1'b0;
            w(8);
        end
        cyc <= 1'b1;
        w(1);
        cyc <= 1'b0;
        w(2);
        bus(1'b0, `DZO_BCNT, 0);
        chk(rd[15:0], n);
        bus(1'b0, `DZO_VCNT, 0);
        chk(rd[15:0], 2);
        chk(rd[31:16], 4);
        conclude();
    end
endmodule // detector_zone_output_logic_tb_top
